// ===== src/monitor_diag.sv
// Device end: diagnostic flags, open-wire sequencing and result clears.
// Assumes commands arrive synchronous to hclk over diag_link_if.
`timescale 1ns/100ps
module monitor_diag (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    diag_link_if.device               link,
    input  wire diag_pkg::dev_state_t dev_state,        // Analog sequencer state
    input  wire logic [15:0]          cmp_threshold,    // Programmed mismatch threshold
    input  wire logic [15:0]          s_result  [16],   // S-converter results
    input  wire logic [15:0]          c_result  [16],   // C-converter results
    input  wire logic                 results_valid,    // Pulse: new result pair
    input  wire logic [15:0]          cmp_a_flag,       // Duplicate comparator A
    input  wire logic [15:0]          cmp_b_flag,       // Duplicate comparator B
    input  wire logic [47:0]          target_a_out,     // Duplicated target A
    input  wire logic [47:0]          target_b_out,     // Duplicated target B
    input  wire logic                 overtemp_trip,    // Die overtemp detector
    input  wire logic                 test_mode_entry,  // Factory test mode entered
    input  wire logic                 osc_fault,        // Oscillator check event
    input  wire logic [7:0]           supply_events,    // Supply/memory error events
    input  wire logic                 ow_cell_req,      // Request cell open-wire
    input  wire logic                 ow_cell_odd,      // Phase requested: 1 odd
    output logic [15:0]               ow_cell_sw,       // Cell open-wire switches
    output logic [8:0]                gpio_src_en,      // GPIO current sources
    output logic                      gpio_src_pullup,  // 1 pull-up, 0 pull-down
    output logic                      aux_start,        // Start first aux converter
    output logic                      aux2_start,       // Start second aux converter
    output logic [4:0]                aux_channel,      // Aux channel select
    output logic                      discharge_off,    // Gate all discharge off
    output logic                      por_req,          // Request power-on reset
    output logic                      sleep_req,        // Enter sleep
    output logic [3:0]                clear_groups      // Pulse: cell, filt, S, aux
);
    import diag_pkg::*;

    logic [15:0] cell_flag_r;     // Cell pair mismatch flags
    logic [7:0]  supply_flag_r;   // Byte 4 flags
    logic [7:0]  diag_flag_r;     // Byte 5 flags
    logic        redund_r;        // Redundant conversion in progress
    logic        cmd_done_r;      // Answer strobe
    logic [47:0] rsp_data_r;      // Answer data
    logic        fwd_r;           // Forwarded soft reset
    logic        sleep_r;         // Sleep request, after forward
    logic [15:0] ow_cell_r;       // Open-wire switch state
    logic [8:0]  gpio_r;          // Current source state
    logic        pup_r;           // Pull-up choice
    logic        aux_r, aux2_r;   // Converter start pulses
    logic [4:0]  ch_r;            // Channel select
    logic [3:0]  clr_r;           // Clear pulses

    // Command decode
    wire is_cmd     = link.cmd_valid;
    wire cell_cmd   = is_cmd && link.cmd == CMD_CELL_CONV;
    wire aux_cmd    = is_cmd && link.cmd == CMD_AUX_CONV;
    wire aux2_cmd   = is_cmd && link.cmd == CMD_AUX2_CONV;
    wire statc_cmd  = is_cmd && link.cmd == CMD_RD_STATC;
    wire cfg_cmd    = is_cmd && link.cmd == CMD_WR_CFGA1;
    wire soft_reset_cmd_cmd   = is_cmd && link.cmd == CMD_SOFT_RST;
    wire sid_cmd    = is_cmd && link.cmd == CMD_RD_SID;
    wire clrf_cmd   = is_cmd && link.cmd == CMD_CLR_FLAGS;
    wire clr_ok     = dev_state == ST_REFERENCE_UP_STATE || dev_state == ST_MEASURE;

    // Aux argument fields: [8] open-wire, [7] pull-up, [4:0] channel
    wire       ow_bit  = link.cmd_arg[8];
    wire       pup_bit = link.cmd_arg[7];
    wire [4:0] ch_sel  = link.cmd_arg[4:0];

    // Per-cell mismatch: threshold or either comparator
    logic [15:0] cell_set;
    genvar g;
    generate
        for (g = 0; g < CELLS; g++) begin : g_cmp
            wire [15:0] diff = (s_result[g] > c_result[g]) ? s_result[g] - c_result[g]
                                                           : c_result[g] - s_result[g];
            assign cell_set[g] = redund_r && results_valid &&
                                 (diff > cmp_threshold || cmp_a_flag[g] || cmp_b_flag[g]);
        end
    endgenerate

    // Events into byte 5; force-error read exercises the fault flag
    wire tflt_set = (target_a_out != target_b_out) || (statc_cmd && link.cmd_arg[0]);
    wire overtemp_shutdown_flag_set = overtemp_trip || (cfg_cmd && link.cmd_arg[FORCE_OVERTEMP_SHUTDOWN_FLAG_BIT]);
    wire tmod_set = test_mode_entry || (cfg_cmd && link.cmd_arg[FORCE_TMOD_BIT]);
    logic [7:0] diag_set;
    always_comb begin
        diag_set           = 8'h00;
        diag_set[SC_OSC]   = osc_fault;
        diag_set[SC_TMOD]  = tmod_set;
        diag_set[SC_OVERTEMP_SHUTDOWN_FLAG]  = overtemp_shutdown_flag_set;
        diag_set[SC_TFLT]  = tflt_set;
    end

    // Clear masks from data bytes 0-1, 4 and 5 of the six
    wire [15:0] cell_clr   = clrf_cmd ? link.cmd_arg[15:0]  : 16'h0000;
    wire [7:0]  supply_clr = clrf_cmd ? link.cmd_arg[39:32] : 8'h00;
    wire [7:0]  diag_clr   = clrf_cmd ? link.cmd_arg[47:40] : 8'h00;

    // Sticky flags; set wins over clear. Reset models power cycle / sleep.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cell_flag_r   <= 16'h0000;
            supply_flag_r <= 8'h00;
            diag_flag_r   <= 8'h08;
        end else begin
            cell_flag_r   <= (cell_flag_r & ~cell_clr) | cell_set;
            supply_flag_r <= (supply_flag_r & ~supply_clr) | supply_events;
            diag_flag_r   <= (diag_flag_r & ~diag_clr) | diag_set;
        end
    end

    // Redundancy mode of the last cell conversion; force bits act on the command itself
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            redund_r <= 1'b0;
        end else begin
            if (cell_cmd) redund_r <= link.cmd_arg[0];
        end
    end

    // Open-wire switches: only one parity at a time
    generate
        for (g = 0; g < CELLS; g++) begin : g_ow
            assign ow_cell_sw[g] = ow_cell_r[g];
        end
    endgenerate
    wire [15:0] odd_mask = 16'h5555;  // Cells 1,3,5.. are index 0,2,4..
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) ow_cell_r <= 16'h0000;
        else ow_cell_r <= !ow_cell_req ? 16'h0000
                        : (ow_cell_odd ? odd_mask : ~odd_mask);
    end

    // Aux starts: each converter only from its own command
    wire [8:0] gpio_pick = (ch_sel == 5'h00) ? 9'h1FF
                         : (ch_sel <= 5'h09) ? 9'(9'h001 << (ch_sel - 5'h01)) : 9'h000;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aux_r <= 1'b0; aux2_r <= 1'b0; ch_r <= 5'h00; gpio_r <= 9'h000; pup_r <= 1'b0;
        end else begin
            aux_r  <= aux_cmd;
            aux2_r <= aux2_cmd;
            if (aux_cmd) begin
                ch_r   <= ch_sel;
                gpio_r <= ow_bit ? gpio_pick : 9'h000;
                pup_r  <= pup_bit;
            end else if (aux2_cmd) begin
                ch_r   <= {1'b0, ch_sel[3:0]};
                gpio_r <= 9'h000;
            end
        end
    end

    // Answers, clears, soft reset
    wire [47:0] statc_word = {diag_flag_r, supply_flag_r, 16'h0000, cell_flag_r};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_done_r <= 1'b0; rsp_data_r <= 48'h0; fwd_r <= 1'b0; sleep_r <= 1'b0;
            clr_r      <= 4'h0;
        end else begin
            cmd_done_r <= statc_cmd || sid_cmd;
            if (sid_cmd) rsp_data_r <= SID_CODE;
            else if (statc_cmd) rsp_data_r <= statc_word;
            fwd_r   <= soft_reset_cmd_cmd;
            sleep_r <= fwd_r;
            clr_r   <= clr_ok && is_cmd ? {link.cmd == CMD_CLR_AUX, link.cmd == CMD_CLR_S,
                       link.cmd == CMD_CLR_FILT, link.cmd == CMD_CLR_CELL} : 4'h0;
        end
    end

    assign link.rsp_valid    = cmd_done_r;
    assign link.rsp_data     = rsp_data_r;
    assign link.rsp_rev      = REV_CODE;
    assign link.rsp_pec      = pec8({REV_CODE, rsp_data_r});
    assign link.fwd_soft_rst = fwd_r;
    assign sleep_req         = sleep_r;
    assign por_req           = overtemp_trip;  // Trip alone resets; flag lags a cycle
    assign discharge_off     = overtemp_trip || diag_flag_r[SC_OVERTEMP_SHUTDOWN_FLAG];
    assign gpio_src_en       = gpio_r;
    assign gpio_src_pullup   = pup_r;
    assign aux_start         = aux_r;
    assign aux2_start        = aux2_r;
    assign aux_channel       = ch_r;
    assign clear_groups      = clr_r;
endmodule : monitor_diag

// ===== src/diag_pkg.sv
// Shared constants and types for the monitor diagnostic flag logic.
// Assumes both ends run on one 40 MHz clock, hclk, with async reset hresetn.
package diag_pkg;

    // Command codes on the command link (values are our own encoding)
    typedef enum logic [3:0] {
        CMD_NONE      = 4'h0,  // No command
        CMD_CELL_CONV = 4'h1,  // Start cell conversion, arg[0] = redundancy
        CMD_AUX_CONV  = 4'h2,  // Start aux conversion
        CMD_AUX2_CONV = 4'h3,  // Start second aux conversion
        CMD_RD_STATC  = 4'h4,  // Read status group C, arg[0] = force error
        CMD_WR_CFGA1  = 4'h5,  // Write config A byte 1
        CMD_SOFT_RST  = 4'h6,  // Soft reset
        CMD_RD_SID    = 4'h7,  // Read unique identifier
        CMD_CLR_CELL  = 4'h8,  // Clear cell results
        CMD_CLR_FILT  = 4'h9,  // Clear filtered results
        CMD_CLR_S     = 4'hA,  // Clear S results
        CMD_CLR_AUX   = 4'hB,  // Clear aux results
        CMD_CLR_FLAGS = 4'hC   // Clear flags, six data bytes in arg
    } cmd_t;

    // Device operating state
    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_REFERENCE_UP_STATE   = 3'b010,
        ST_MEASURE = 3'b100
    } dev_state_t;

    localparam int          CELLS        = 16;
    localparam int          GPIOS        = 9;
    localparam logic [15:0] CLEAR_VALUE  = 16'h8000;
    localparam int          FORCE_OVERTEMP_SHUTDOWN_FLAG_BIT = 4;
    localparam int          FORCE_TMOD_BIT = 7;
    localparam logic [3:0]  REV_CODE     = 4'h1;            // Arbitrary value
    localparam logic [47:0] SID_CODE     = 48'h0123456789AB; // Arbitrary value

    // Status group C byte 5 positions
    localparam int SC_OSC   = 0;
    localparam int SC_TMOD  = 1;
    localparam int SC_OVERTEMP_SHUTDOWN_FLAG  = 2;
    localparam int SC_SLEEP = 3;
    localparam int SC_TFLT  = 4;

    // Clear-flag data byte indices
    localparam int CFB_CELL_LO = 0;
    localparam int CFB_CELL_HI = 1;
    localparam int CFB_SUPPLY  = 4;
    localparam int CFB_DIAG    = 5;

    // Host register offsets (AHB-Lite byte addresses)
    localparam logic [7:0] A_CMD    = 8'h00;  // W: [3:0] cmd, start on write
    localparam logic [7:0] A_ARG_LO = 8'h04;  // W: argument bytes 0..3
    localparam logic [7:0] A_ARG_HI = 8'h08;  // W: argument bytes 4..5
    localparam logic [7:0] A_STAT   = 8'h0C;  // R: [0] busy [1] recovered
    localparam logic [7:0] A_RD_LO  = 8'h10;  // R: read data bits 31:0
    localparam logic [7:0] A_RD_HI  = 8'h14;  // R: read data bits 47:32
    localparam logic [7:0] A_RD_REV = 8'h18;  // R: revision + pec
    localparam logic [7:0] A_AUXCMP = 8'h1C;  // W: aux1 lo, aux2 hi; R: [0] mismatch

    // Packet error code over revision and data, shared by both ends
    function automatic logic [7:0] pec8(input logic [51:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 51; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : pec8

endpackage : diag_pkg

// ===== src/diag_link_if.sv
// Command link between host controller and monitor device.
// Assumes one clock; a command lasts one cycle, answer within a few cycles.
`timescale 1ns/100ps
interface diag_link_if;
    import diag_pkg::*;
    logic        cmd_valid;   // One-cycle command strobe
    cmd_t        cmd;         // Command code
    logic [47:0] cmd_arg;     // Command argument / six data bytes
    logic        rsp_valid;   // One-cycle answer strobe
    logic [47:0] rsp_data;    // Read data
    logic [3:0]  rsp_rev;     // Revision code
    logic [7:0]  rsp_pec;     // Packet error code over rev and data
    logic        fwd_soft_rst; // Soft reset forwarded to next device

    modport device (input cmd_valid, cmd, cmd_arg,
                    output rsp_valid, rsp_data, rsp_rev, rsp_pec, fwd_soft_rst);
    modport host   (output cmd_valid, cmd, cmd_arg,
                    input rsp_valid, rsp_data, rsp_rev, rsp_pec, fwd_soft_rst);
endinterface : diag_link_if

// ===== src/diag_host.sv
// Host end: AHB-Lite registers drive commands onto the link.
// Assumes a single AHB-Lite master; one command outstanding at a time.
`timescale 1ns/100ps
module diag_host (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    diag_link_if.host        link
);
    import diag_pkg::*;

    logic        wr_pend_r;    // Write data phase pending
    logic [7:0]  wr_addr_r;    // Latched write offset
    logic [47:0] arg_r;        // Command argument
    logic        cmd_go_r;     // Command strobe
    cmd_t        cmd_r;        // Command code
    logic        busy_r;       // Awaiting answer
    logic [47:0] rd_r;         // Captured read data
    logic [11:0] rev_pec_r;    // Revision and received pec
    logic        pec_ok_r;     // Pec checked including revision
    logic        recov_r;      // Test flag reads back 0 after clear
    logic [31:0] aux12_r;      // Aux results to compare
    logic [31:0] rdata_r;      // Read data register

    wire        take   = hsel && hready && htrans[1];
    wire [7:0]  a      = haddr[7:0];
    wire [31:0] rd_mux = (a == A_STAT)   ? {29'h0, pec_ok_r, recov_r, busy_r}
                       : (a == A_RD_LO)  ? rd_r[31:0]
                       : (a == A_RD_HI)  ? {16'h0, rd_r[47:32]}
                       : (a == A_RD_REV) ? {20'h0, rev_pec_r}
                       : (a == A_AUXCMP) ? {31'h0, aux12_r[15:0] != aux12_r[31:16]}
                       : 32'h0;

    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0; wr_addr_r <= 8'h00; rdata_r <= 32'h0;
        end else begin
            wr_pend_r <= take && hwrite;
            if (take) wr_addr_r <= a;
            if (take && !hwrite) rdata_r <= rd_mux;
        end
    end

    // Register writes and command issue
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arg_r <= 48'h0; cmd_go_r <= 1'b0; cmd_r <= CMD_NONE; aux12_r <= 32'h0;
        end else begin
            cmd_go_r <= 1'b0;
            if (wr_pend_r) begin
                if (wr_addr_r == A_CMD) begin
                    cmd_r    <= cmd_t'(hwdata[3:0]);
                    cmd_go_r <= 1'b1;
                end else if (wr_addr_r == A_ARG_LO) arg_r[31:0]  <= hwdata;
                else if (wr_addr_r == A_ARG_HI)     arg_r[47:32] <= hwdata[15:0];
                else if (wr_addr_r == A_AUXCMP)     aux12_r      <= hwdata;
            end
        end
    end

    // Answer capture; recovered when test flag reads 0
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_r <= 1'b0; rd_r <= 48'h0; rev_pec_r <= 12'h0; pec_ok_r <= 1'b0;
            recov_r <= 1'b0;
        end else begin
            if (cmd_go_r && (cmd_r == CMD_RD_STATC || cmd_r == CMD_RD_SID)) busy_r <= 1'b1;
            else if (link.rsp_valid) busy_r <= 1'b0;
            if (link.rsp_valid) begin
                rd_r      <= link.rsp_data;
                rev_pec_r <= {link.rsp_rev, link.rsp_pec};
                pec_ok_r  <= pec8({link.rsp_rev, link.rsp_data}) == link.rsp_pec;
                if (cmd_r == CMD_RD_STATC)
                    recov_r <= !link.rsp_data[40 + SC_TMOD];
            end
        end
    end

    assign link.cmd_valid = cmd_go_r;
    assign link.cmd       = cmd_r;
    assign link.cmd_arg   = arg_r;
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign hrdata         = rdata_r;
endmodule : diag_host

// ===== test/diag_sva.sv
// Concurrent checks on the command link and on the device outputs.
// Assumes one hclk domain; hresetn is asynchronous and active low.
`timescale 1ns/100ps
module diag_sva
    import diag_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        cmd_valid,
    input wire cmd_t        cmd,
    input wire logic        rsp_valid,
    input wire logic [47:0] rsp_data,
    input wire logic [3:0]  rsp_rev,
    input wire logic        fwd_soft_rst,
    input wire logic        sleep_req,
    input wire logic [15:0] ow_cell_sw,
    input wire logic        aux2_start,
    input wire logic [3:0]  clear_groups,
    input wire dev_state_t  dev_state,
    input wire logic        overtemp_trip,
    input wire logic        discharge_off,
    input wire logic        por_req
);
    // One domain, so clock and disable are given once
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_sid_answer: assert property (
        cmd_valid && cmd == CMD_RD_SID |=> rsp_valid && rsp_data == SID_CODE)
        else $error("identifier answer wrong");
    a_soft_chain: assert property (
        cmd_valid && cmd == CMD_SOFT_RST |=> fwd_soft_rst ##1 sleep_req)
        else $error("soft reset not forwarded before sleep");
    a_rev_fixed: assert property (rsp_valid |-> rsp_rev == REV_CODE)
        else $error("revision code changed");
    a_rsp_cause: assert property (
        rsp_valid |-> $past(cmd_valid) && ($past(cmd) inside {CMD_RD_STATC, CMD_RD_SID}))
        else $error("answer without read command");
    a_odd_even: assert property ((ow_cell_sw & {ow_cell_sw[14:0], 1'b0}) == 16'h0000)
        else $error("adjacent open wire switches closed");
    a_aux_apart: assert property (
        aux2_start |-> $past(cmd_valid) && $past(cmd) == CMD_AUX2_CONV)
        else $error("second converter started by wrong command");
    a_clear_gate: assert property (
        clear_groups != 4'h0 |-> $past(cmd_valid) && $past(dev_state) != ST_STANDBY)
        else $error("clear outside allowed states");
    a_clear_cell: assert property (
        cmd_valid && cmd inside {CMD_CLR_CELL, CMD_CLR_FILT, CMD_CLR_S} && dev_state != ST_STANDBY
        |=> clear_groups == 4'(4'h1 << ($past(cmd) - 4'h8)))
        else $error("cell clear pulse wrong");
    a_clear_aux: assert property (
        cmd_valid && cmd == CMD_CLR_AUX && dev_state != ST_STANDBY |=> clear_groups == 4'h8)
        else $error("aux clear pulse wrong");
    a_trip_gate: assert property (overtemp_trip |-> discharge_off && por_req)
        else $error("discharge left on at trip");
endmodule : diag_sva

// ===== test/tb_monitor_diagnostic_flag_logic.sv
// Bench: host end driven over AHB-Lite, device inputs driven directly.
// Assumes both ends meet in diag_link_if; link answers are scored from a queue.
`timescale 1ns/100ps
module tb_monitor_diagnostic_flag_logic;
    import diag_pkg::*;
    logic        hclk, hresetn, hwrite, results_valid, overtemp_trip, test_mode_entry;
    logic        osc_fault, ow_cell_req, ow_cell_odd, hreadyout, gpio_src_pullup;
    logic        aux_start, aux2_start, discharge_off, sleep_req, por_req;
    logic [4:0]  aux_channel;
    logic [1:0]  htrans;
    logic [7:0]  supply_events, sb;
    logic [8:0]  gpio_src_en, src_seen;
    logic [3:0]  clear_groups;
    logic [15:0] cmp_threshold, cmp_a_flag, cmp_b_flag, ow_cell_sw;
    logic [15:0] s_result [16];
    logic [15:0] c_result [16];
    logic [31:0] haddr, hwdata, hrdata, rd_word;
    logic [47:0] target_a_out, target_b_out, want;
    dev_state_t  dev_state;
    logic [47:0] exp_q [$];  // Expected link answers, oldest first
    int          err_count, checks_done;
    int          fpos [7] = '{SC_OVERTEMP_SHUTDOWN_FLAG, SC_TMOD, SC_TMOD, SC_OVERTEMP_SHUTDOWN_FLAG, SC_OSC, SC_TFLT, SC_TFLT};

    diag_link_if lnk ();
    diag_host u_diag_host (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp(),
        .link(lnk.host));
    monitor_diag u_monitor_diag (.hclk, .hresetn, .link(lnk.device), .dev_state,
        .cmp_threshold, .s_result, .c_result, .results_valid, .cmp_a_flag, .cmp_b_flag,
        .target_a_out, .target_b_out, .overtemp_trip, .test_mode_entry, .osc_fault,
        .supply_events, .ow_cell_req, .ow_cell_odd, .ow_cell_sw, .gpio_src_en,
        .gpio_src_pullup, .aux_start, .aux2_start, .aux_channel, .discharge_off,
        .por_req, .sleep_req, .clear_groups);
    diag_sva u_diag_sva (.hclk, .hresetn, .cmd_valid(lnk.cmd_valid), .cmd(lnk.cmd),
        .rsp_valid(lnk.rsp_valid), .rsp_data(lnk.rsp_data), .rsp_rev(lnk.rsp_rev),
        .fwd_soft_rst(lnk.fwd_soft_rst), .sleep_req, .ow_cell_sw, .aux2_start,
        .clear_groups, .dev_state, .overtemp_trip, .discharge_off, .por_req);

    // 40 MHz clock
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // Scorer: each link answer is matched to the oldest note; a stray one fails on X
    always @(posedge hclk) begin
        if (lnk.rsp_valid === 1'b1) begin
            chk(lnk.rsp_data, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
        end
        // Sources applied so far in a sweep; each aux start begins a new one
        src_seen <= aux_start ? gpio_src_en : src_seen | gpio_src_en;
    end

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // Bounded wait for hready; a hang ends the run as a mismatch
    task automatic edge_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (hreadyout !== 1'b1) begin
            err_count++;
            final_report();
        end
    endtask : edge_ready

    // One single AHB-Lite transfer; read data lands in rd_word
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hwrite <= w;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        edge_ready();
        htrans <= 2'b00;
        hwdata <= d;
        edge_ready();
        rd_word = hrdata;
    endtask : ahb

    // Argument words first, then the command word that launches it
    task automatic send(input cmd_t c, input logic [47:0] arg);
        ahb(1'b1, A_ARG_LO, arg[31:0]);
        ahb(1'b1, A_ARG_HI, {16'h0, arg[47:32]});
        ahb(1'b1, A_CMD, {28'h0, c});
        repeat (4) @(posedge hclk);
    endtask : send

    task automatic stat_c(input logic [47:0] e, input logic force_bit);
        exp_q.push_back(e);
        send(CMD_RD_STATC, {47'h0, force_bit});
    endtask : stat_c

    initial begin
        void'($urandom(32'h62df));
        {hresetn, hwrite, results_valid, overtemp_trip, test_mode_entry, osc_fault} = '0;
        {ow_cell_req, ow_cell_odd, htrans, supply_events, cmp_a_flag, cmp_b_flag} = '0;
        {haddr, hwdata} = '0;
        cmp_threshold = 16'h0010;
        dev_state = ST_MEASURE;
        target_a_out = {16'($urandom), $urandom};
        target_b_out = target_a_out;
        for (int i = 0; i < 16; i++) begin
            s_result[i] = 16'h1000;
            c_result[i] = 16'h1000;
        end
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        stat_c(48'h0800_0000_0000, 1'b0);
        send(CMD_CLR_FLAGS, 48'h0800_0000_0000);
        stat_c(48'h0, 1'b0);
        ahb(1'b0, 8'h40, 32'h0);
        chk(rd_word, 48'h0);
        exp_q.push_back(SID_CODE);
        send(CMD_RD_SID, 48'h0);
        ahb(1'b0, A_STAT, 32'h0);
        chk(rd_word, 48'h6);
        ahb(1'b0, A_RD_REV, 32'h0);
        chk(rd_word, 48'({REV_CODE, pec8({REV_CODE, SID_CODE})}));
        $display("test 1 done");
        // Each event sets one sticky flag, which is then cleared by position
        sb = 8'h01 << $urandom_range(7);
        for (int i = 0; i < 8; i++) begin
            case (i)
                0: send(CMD_WR_CFGA1, 48'h10);
                1: send(CMD_WR_CFGA1, 48'h80);
                2: test_mode_entry <= 1'b1;
                3: overtemp_trip <= 1'b1;
                4: osc_fault <= 1'b1;
                5: target_b_out <= ~target_a_out;
                6: stat_c(48'h0, 1'b1);
                default: supply_events <= sb;
            endcase
            @(posedge hclk);
            {test_mode_entry, overtemp_trip, osc_fault, supply_events} <= '0;
            target_b_out <= target_a_out;
            want = (i == 7) ? {8'h00, sb, 32'h0} : 48'h1 << (40 + fpos[i]);
            stat_c(want, 1'b0);
            ahb(1'b0, A_STAT, 32'h0);
            chk(rd_word, want[40 + SC_TMOD] ? 48'h4 : 48'h6);
            send(CMD_CLR_FLAGS, want);
            stat_c(48'h0, 1'b0);
        end
        $display("test 2 done");
        // A flag raised during its own clear must survive it
        ahb(1'b1, A_ARG_LO, 32'h0);
        ahb(1'b1, A_ARG_HI, 32'h0100);
        ahb(1'b1, A_CMD, {28'h0, CMD_CLR_FLAGS});
        osc_fault <= 1'b1;  // Only in the cycle the clear is taken
        @(posedge hclk);
        osc_fault <= 1'b0;
        stat_c(48'h0100_0000_0000, 1'b0);
        send(CMD_CLR_FLAGS, 48'h0100_0000_0000);
        // Mismatch by threshold and by one comparator, with and without redundancy
        for (int r = 0; r < 2; r++) begin
            int k;
            int j;
            k = $urandom_range(15);
            j = $urandom_range(15);
            send(CMD_CELL_CONV, 48'(r));
            s_result[k] <= 16'h1020;
            cmp_b_flag <= 16'h1 << j;
            results_valid <= 1'b1;
            @(posedge hclk);
            s_result[k] <= 16'h1000;
            cmp_b_flag <= 16'h0;
            results_valid <= 1'b0;
            want = r ? (48'h1 << k) | (48'h1 << j) : 48'h0;
            stat_c(want, 1'b0);
            send(CMD_CLR_FLAGS, want);
            stat_c(48'h0, 1'b0);
        end
        $display("test 3 done");
        // Every result clear in every state; the checker judges the pulses
        for (int s = 0; s < 3; s++) begin
            dev_state <= dev_state_t'(3'b001 << s);
            for (int c = 8; c < 12; c++) send(cmd_t'(c), 48'h0);
        end
        // Cell open wire phases
        ow_cell_req <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            ow_cell_odd <= p[0];
            repeat (3) @(posedge hclk);
            chk(ow_cell_sw, p ? 48'h5555 : 48'hAAAA);
        end
        ow_cell_req <= 1'b0;
        // Aux sweep on channel 0 with open wire, all nine sources at once, both source directions
        for (int p = 0; p < 2; p++) begin
            send(CMD_AUX_CONV, 48'h0);
            chk(gpio_src_en, 48'h0);
            send(CMD_AUX_CONV, 48'h100 | (48'(p) << 7));
            repeat (300) @(posedge hclk);
            chk(src_seen, 48'h1FF);
            chk(gpio_src_pullup, 48'(p));
            ahb(1'b1, A_AUXCMP, {8'h0, sb, 8'h0, sb ^ 8'(p)});
            ahb(1'b0, A_AUXCMP, 32'h0);
            chk(rd_word, 48'(p));
        end
        send(CMD_AUX2_CONV, 48'h1F);
        chk(aux_channel, 48'h0F);
        send(CMD_SOFT_RST, 48'h0);
        $display("test 4 done");
        chk(48'(exp_q.size()), 48'h0);
        final_report();
    end
endmodule : tb_monitor_diagnostic_flag_logic
